// *** verilog/hpr_map.vh ***
// Register map, field positions, reset values and timing constants of the
// power-control block. Assumes inclusion by bare name from design files.
`ifndef HPR_MAP_VH
`define HPR_MAP_VH
`define HPR_OFF_CNT      12'h000
`define HPR_OFF_MATCH0   12'h004
`define HPR_OFF_MATCH1   12'h008
`define HPR_OFF_LOAD     12'h00c
`define HPR_OFF_CTL      12'h010
`define HPR_OFF_IM       12'h014
`define HPR_OFF_RIS      12'h018
`define HPR_OFF_MIS      12'h01c
`define HPR_OFF_IC       12'h020
`define HPR_OFF_TRIM     12'h024
`define HPR_CTL_SECONDS_COUNTER_ENABLE    0
`define HPR_CTL_REQ      1
`define HPR_CTL_SEL      2
`define HPR_CTL_MWEN     3
`define HPR_CTL_PWEN     4
`define HPR_CTL_BATEN    5
`define HPR_CTL_CLKEN    6
`define HPR_CTL_ABORT    7
`define HPR_CTL_W        8
`define HPR_EV_M0        0
`define HPR_EV_M1        1
`define HPR_EV_BAT       2
`define HPR_EV_WAKE      3
`define HPR_EV_W         4
`define HPR_TRIM_RST     16'h7fff
`define HPR_NOM_DIV      16'h7fff
`define HPR_TRIM_PERIOD  6'h3f
`define HPR_XTAL_DIV     7'h7f
`endif

// *** verilog/hpr_sync.v ***
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slowly changing level or a clock slower than half
// of core_clk.
`timescale 1ns/100ps
module hpr_sync (
	input  wire core_clk,
	input  wire rst_b,
	input  wire clkEn,
	input  wire asyncIn,
	output wire syncOut
);
	reg stage1_reg;
	reg stage2_reg;
	// ----------------------------------------------------------------
	// Sync chain
	// ----------------------------------------------------------------
	// The first stage feeds only the second stage.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else if (clkEn) begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end
	assign syncOut = stage2_reg;
endmodule

// *** verilog/hpr_refgen.v ***
// Reference tick generator: selects the divided crystal or the direct slow
// oscillator and emits one core_clk pulse per reference rising edge.
// Assumes oscIn is already synchronised to core_clk.
`timescale 1ns/100ps
`include "hpr_map.vh"
module hpr_refgen (
	input  wire core_clk,
	input  wire rst_b,
	input  wire clkEn,
	input  wire srcEnable,
	input  wire srcSelect,
	input  wire oscIn,
	output reg  refTick
);
	reg       oscDly_reg;
	reg [6:0] xtalDiv_reg;
	wire      oscRise;
	assign oscRise = oscIn & ~oscDly_reg;
	// ----------------------------------------------------------------
	// Divider and select
	// ----------------------------------------------------------------
	// The crystal path counts 128 input edges per reference tick.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			oscDly_reg  <= 1'b0;
			xtalDiv_reg <= 7'h00;
			refTick     <= 1'b0;
		end else if (clkEn) begin
			oscDly_reg <= oscIn;
			refTick    <= 1'b0;
			if (!srcEnable) begin
				xtalDiv_reg <= 7'h00;
			end else if (srcSelect) begin
				refTick <= oscRise;
			end else if (oscRise) begin
				xtalDiv_reg <= xtalDiv_reg + 7'h01;
				refTick     <= (xtalDiv_reg == `HPR_XTAL_DIV);
			end
		end
	end
endmodule

// *** verilog/hpr_top.v ***
// Always-powered power-control block: seconds counter with trimmable
// predivider, two match registers, battery monitor and regulator control.
// Assumes an APB master on core_clk; pins arrive asynchronously.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`include "hpr_map.vh"
module hpr_top (
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        clkEn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        osc_in_pin,
	output wire        osc_out_pin,
	input  wire        resumeIn_b,
	input  wire        batteryBelow,
	output reg         regulator_off_n,
	output wire        irq
);
	// ----------------------------------------------------------------
	// Power states
	// ----------------------------------------------------------------
	localparam [1:0] ST_RUN = 2'b01;
	localparam [1:0] ST_HIB = 2'b10;

	reg  [1:0]              state_reg;
	reg  [`HPR_CTL_W-1:0]   sleep_control_reg;
	reg  [31:0]             seconds_counter_reg;
	reg  [31:0]             seconds_match0_reg;
	reg  [31:0]             seconds_match1_reg;
	reg  [15:0]             predivider_trim_reg;
	reg  [15:0]             prediv_reg;
	reg  [5:0]              secPhase_reg;
	reg  [`HPR_EV_W-1:0]    raw_event_status_reg;
	reg  [`HPR_EV_W-1:0]    irqMask_reg;
	reg                     m0Dly_reg;
	reg                     m1Dly_reg;
	reg                     resumeDly_reg;
	reg  [`HPR_EV_W-1:0]    evSet;
	wire                    oscSync;
	wire                    resumeSync;
	wire                    batSync;
	wire                    refTick;
	wire                    secTick;
	wire                    wrEn;
	wire                    rdEn;
	wire                    match0;
	wire                    match1;
	wire                    resumeAct;
	wire                    batLow;
	wire                    hibernating;
	wire [15:0]             divisor;

	wire slowClockEnable       = sleep_control_reg[`HPR_CTL_CLKEN];
	wire slowClockSourceSelect = sleep_control_reg[`HPR_CTL_SEL];
	wire batteryMonitorEnable  = sleep_control_reg[`HPR_CTL_BATEN];
	wire abortOnWeakBattery    = sleep_control_reg[`HPR_CTL_ABORT];
	wire secondsCounterEnable  = sleep_control_reg[`HPR_CTL_SECONDS_COUNTER_ENABLE];
	wire matchResumeEnable     = sleep_control_reg[`HPR_CTL_MWEN];
	wire pinResumeEnable       = sleep_control_reg[`HPR_CTL_PWEN];

	// ----------------------------------------------------------------
	// Pin synchronisers and reference
	// ----------------------------------------------------------------
	hpr_sync uSyncOsc (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clkEn    (clkEn),
		.asyncIn  (osc_in_pin),
		.syncOut  (oscSync)
	);
	// The pin is inverted ahead of the chain so that the reset value of the
	// chain matches the idle level and no false wake edge follows reset.
	hpr_sync uSyncWake (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clkEn    (clkEn),
		.asyncIn  (~resumeIn_b),
		.syncOut  (resumeSync)
	);
	hpr_sync uSyncBat (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clkEn    (clkEn),
		.asyncIn  (batteryBelow),
		.syncOut  (batSync)
	);
	hpr_refgen uRef (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clkEn     (clkEn),
		.srcEnable (slowClockEnable),
		.srcSelect (slowClockSourceSelect),
		.oscIn     (oscSync),
		.refTick   (refTick)
	);

	// The crystal return pin drives the inverse of the input while the source is enabled.
	assign osc_out_pin = slowClockEnable & ~osc_in_pin;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; reads never disturb state, so any spacing works.
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wrEn    = psel & penable & pwrite;
	assign rdEn    = psel & ~pwrite;

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	assign hibernating = (state_reg == ST_HIB);
	assign match0      = (seconds_counter_reg == seconds_match0_reg);
	assign match1      = (seconds_counter_reg == seconds_match1_reg);
	assign resumeAct   = resumeSync;
	// Battery is sampled only while awake and monitoring.
	assign batLow = batteryMonitorEnable & batSync & ~hibernating;

	// Rising edges of the match and wake conditions set sticky flags.
	always @* begin
		evSet               = {`HPR_EV_W{1'b0}};
		evSet[`HPR_EV_M0]   = match0 & ~m0Dly_reg;
		evSet[`HPR_EV_M1]   = match1 & ~m1Dly_reg;
		evSet[`HPR_EV_BAT]  = batLow;
		evSet[`HPR_EV_WAKE] = resumeAct & ~resumeDly_reg;
	end

	// ----------------------------------------------------------------
	// Predivider
	// ----------------------------------------------------------------
	// Trim divisor applies in the last second of each 64-second round.
	assign divisor = (secPhase_reg == `HPR_TRIM_PERIOD) ?
		predivider_trim_reg : `HPR_NOM_DIV;
	assign secTick = refTick & secondsCounterEnable &
		(prediv_reg == 16'h0000);

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prediv_reg   <= `HPR_NOM_DIV;
			secPhase_reg <= 6'h00;
		end else if (clkEn && refTick && secondsCounterEnable) begin
			if (prediv_reg == 16'h0000) begin
				secPhase_reg <= secPhase_reg + 6'h01;
				// Next second's divisor is loaded at the boundary.
				if (secPhase_reg + 6'h01 == `HPR_TRIM_PERIOD)
					prediv_reg <= predivider_trim_reg;
				else
					prediv_reg <= `HPR_NOM_DIV;
			end else begin
				prediv_reg <= prediv_reg - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Seconds counter, match, trim and control registers
	// ----------------------------------------------------------------
	// Software spacing of timed writes is assumed, not enforced.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			seconds_counter_reg <= 32'h0000_0000;
			seconds_match0_reg  <= 32'hffff_ffff;
			seconds_match1_reg  <= 32'hffff_ffff;
			predivider_trim_reg <= `HPR_TRIM_RST;
			sleep_control_reg   <= {`HPR_CTL_W{1'b0}};
			irqMask_reg         <= {`HPR_EV_W{1'b0}};
		end else if (clkEn) begin
			if (wrEn && paddr == `HPR_OFF_LOAD)
				seconds_counter_reg <= pwdata;
			else if (secTick)
				seconds_counter_reg <= seconds_counter_reg + 32'h1;
			if (wrEn && paddr == `HPR_OFF_MATCH0)
				seconds_match0_reg <= pwdata;
			if (wrEn && paddr == `HPR_OFF_MATCH1)
				seconds_match1_reg <= pwdata;
			if (wrEn && paddr == `HPR_OFF_TRIM)
				predivider_trim_reg <= pwdata[15:0];
			if (wrEn && paddr == `HPR_OFF_IM)
				irqMask_reg <= pwdata[`HPR_EV_W-1:0];
			if (wrEn && paddr == `HPR_OFF_CTL)
				sleep_control_reg <= pwdata[`HPR_CTL_W-1:0];
			else if (state_reg == ST_HIB || (sleep_control_reg[`HPR_CTL_REQ]
					&& abortOnWeakBattery && batLow))
				sleep_control_reg[`HPR_CTL_REQ] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Raw status with write-one-to-clear
	// ----------------------------------------------------------------
	// A new event in the clearing cycle stays set.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			raw_event_status_reg <= {`HPR_EV_W{1'b0}};
			m0Dly_reg            <= 1'b0;
			m1Dly_reg            <= 1'b0;
			resumeDly_reg        <= 1'b0;
		end else if (clkEn) begin
			m0Dly_reg     <= match0;
			m1Dly_reg     <= match1;
			resumeDly_reg <= resumeAct;
			if (wrEn && paddr == `HPR_OFF_IC)
				raw_event_status_reg <= (raw_event_status_reg &
					~pwdata[`HPR_EV_W-1:0]) | evSet;
			else
				raw_event_status_reg <= raw_event_status_reg | evSet;
		end
	end

	// Unmasked pending events merge into one request line.
	assign irq = |(raw_event_status_reg & irqMask_reg) & ~hibernating;

	// ----------------------------------------------------------------
	// Power sequencer
	// ----------------------------------------------------------------
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg       <= ST_RUN;
			regulator_off_n <= 1'b1;
		end else if (clkEn) begin
			case (state_reg)
			ST_RUN: begin
				regulator_off_n <= 1'b1;
				if (sleep_control_reg[`HPR_CTL_REQ] &&
						!(abortOnWeakBattery && batLow)) begin
					state_reg       <= ST_HIB;
					regulator_off_n <= 1'b0;
				end
			end
			ST_HIB: begin
				if ((pinResumeEnable && resumeAct) ||
						(matchResumeEnable && (match0 || match1))) begin
					state_reg       <= ST_RUN;
					regulator_off_n <= 1'b1;
				end
			end
			default: begin
				state_reg       <= ST_RUN;
				regulator_off_n <= 1'b1;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Read data is registered during the setup cycle; unmapped reads zero.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (clkEn && rdEn && !penable) begin
			case (paddr)
			`HPR_OFF_CNT:    prdata <= seconds_counter_reg;
			`HPR_OFF_MATCH0: prdata <= seconds_match0_reg;
			`HPR_OFF_MATCH1: prdata <= seconds_match1_reg;
			`HPR_OFF_CTL:    prdata <= {24'h0, sleep_control_reg};
			`HPR_OFF_IM:     prdata <= {28'h0, irqMask_reg};
			`HPR_OFF_RIS:    prdata <= {28'h0, raw_event_status_reg};
			`HPR_OFF_MIS:    prdata <= {28'h0,
				raw_event_status_reg & irqMask_reg};
			`HPR_OFF_TRIM:   prdata <= {16'h0, predivider_trim_reg};
			default:         prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// *** tb/hpr_partner.sv ***
// Far-side model: reference oscillator, resume source, battery sense and
// the regulator. Assumes the bench steers wakeReq and batLow off the edge.
`timescale 1ns/100ps
module hpr_partner (
	input  wire regulator_off_n,
	input  wire wakeReq,
	input  wire batLow,
	output reg  osc_in_pin,
	output wire resumeIn_b,
	output wire batteryBelow,
	output reg  powerGood
);
	// The oscillator runs free, even when the counter is not used.
	initial begin
		osc_in_pin = 1'b0;
		forever #30 osc_in_pin = ~osc_in_pin;
	end
	// The resume line has a pull-up, so it idles high.
	assign resumeIn_b   = ~wakeReq;
	assign batteryBelow = batLow;
	// Main supply follows the regulator enable after a short ramp.
	initial powerGood = 1'b0;
	always @(regulator_off_n) begin
		powerGood <= #30 regulator_off_n;
	end
endmodule

// *** tb/hpr_props.sv ***
// Checker for the power-control block, watching only its ports.
// Assumes core_clk is the one clock and rst_b its async low reset.
`timescale 1ns/100ps
`include "hpr_map.vh"
module hpr_props (
	input wire        core_clk,
	input wire        rst_b,
	input wire        clkEn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        osc_in_pin,
	input wire        osc_out_pin,
	input wire        resumeIn_b,
	input wire        batteryBelow,
	input wire        regulator_off_n,
	input wire        irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// A completed control write, a settled weak battery, a read setup.
	sequence ctlWrite;
		clkEn && psel && penable && pwrite && paddr == `HPR_OFF_CTL;
	endsequence
	sequence weakBattery;
		batteryBelow [*4];
	endsequence
	sequence readSetup;
		clkEn && psel && !penable && !pwrite;
	endsequence
	ready_const_a: assert property (pready)
		else $error("pready low");
	no_error_a: assert property (!pslverr)
		else $error("pslverr high");
	sleep_entry_a: assert property (
		ctlWrite ##0 (pwdata[1] && !pwdata[7]) |-> ##[1:3] !regulator_off_n)
		else $error("sleep request did not cut power");
	abort_hold_a: assert property (
		weakBattery ##0 ctlWrite ##0 (pwdata[1] && pwdata[5] && pwdata[7]
		&& regulator_off_n) |-> ##1 regulator_off_n [*4])
		else $error("power cut despite weak battery");
	unmapped_zero_a: assert property (
		readSetup ##0 (paddr > `HPR_OFF_TRIM) |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	load_reads_a: assert property (
		readSetup ##0 (paddr == `HPR_OFF_LOAD) |=> prdata == 32'h0)
		else $error("load register read not zero");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata))
		else $error("read data changed without a read");
	irq_quiet_a: assert property (!regulator_off_n [*2] |-> !irq)
		else $error("interrupt while powered down");
	osc_drive_a: assert property (osc_in_pin |-> !osc_out_pin)
		else $error("crystal drive not inverted");
endmodule
bind hpr_top hpr_props u_hpr_props (.*);

// *** tb/tb_top.sv ***
// Self-checking bench for the power-control block over APB.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/100ps
`include "hpr_map.vh"
module tb_top;
	localparam int WR_GAP = 4; // Extra idle cycles after each write, on top of the one that ends it.
	reg        core_clk, rst_b, psel, penable, pwrite, wakeReq, batLow;
	reg        clkEn;
	reg [11:0] paddr;
	reg [31:0] pwdata;
	wire [31:0] prdata;
	wire       pready, pslverr, osc_in_pin, osc_out_pin, resumeIn_b;
	wire       batteryBelow, regulator_off_n, irq, powerGood;
	int        fail_count, n_compared;
	hpr_top u_hpr_top (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_in_pin(osc_in_pin),
		.osc_out_pin(osc_out_pin), .resumeIn_b(resumeIn_b),
		.batteryBelow(batteryBelow), .regulator_off_n(regulator_off_n),
		.irq(irq));
	hpr_partner u_hpr_partner (.regulator_off_n(regulator_off_n),
		.wakeReq(wakeReq), .batLow(batLow), .osc_in_pin(osc_in_pin),
		.resumeIn_b(resumeIn_b), .batteryBelow(batteryBelow),
		.powerGood(powerGood));
	// Compares one value and counts the outcome.
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer; hold keeps psel up for a setup right after.
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
		bit hold, output logic [31:0] rd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			test_done;
		end
		rd = prdata;
		penable <= 1'b0;
		if (!hold) begin
			psel <= 1'b0;
			@(posedge core_clk);
		end
		if (w)
			repeat (WR_GAP) @(posedge core_clk);
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		logic [31:0] rd;
		apb(1'b1, a, d, 1'b0, rd);
	endtask
	task automatic rdc(logic [11:0] a, logic [31:0] exp, string what,
		bit hold);
		logic [31:0] rd;
		apb(1'b0, a, 32'h0, hold, rd);
		check(what, rd, exp);
	endtask
	// Waits, bounded, for the regulator enable to reach a level.
	task automatic wait_reg(logic lvl);
		int n;
		n = 0;
		while (regulator_off_n !== lvl && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		check("regulator_off_n", regulator_off_n, lvl);
		if (regulator_off_n !== lvl)
			test_done;
	endtask
	// Reset values, back-to-back reads, trim read and write.
	task automatic t_regs;
		check("osc drive off", osc_out_pin, 1'b0);
		rdc(`HPR_OFF_TRIM, 32'h7fff, "trim reset", 1);
		rdc(`HPR_OFF_CTL, 32'h0, "ctl reset", 1);
		rdc(12'h100, 32'h0, "unmapped", 0);
		wr(`HPR_OFF_TRIM, 32'h8001);
		rdc(`HPR_OFF_TRIM, 32'h8001, "trim rw", 0);
		rdc(`HPR_OFF_LOAD, 32'h0, "load read", 0);
	endtask
	// Match event by loading the counter, then mask and clear.
	task automatic t_match;
		wr(`HPR_OFF_CTL, 32'h45);
		check("osc drive", osc_out_pin, !osc_in_pin);
		wr(`HPR_OFF_MATCH0, 32'h5);
		wr(`HPR_OFF_IM, 32'h1);
		wr(`HPR_OFF_LOAD, 32'h5);
		wr(`HPR_OFF_CNT, 32'h7);
		rdc(`HPR_OFF_CNT, 32'h5, "count loaded", 1);
		rdc(`HPR_OFF_RIS, 32'h1, "match raw", 1);
		rdc(`HPR_OFF_MIS, 32'h1, "match masked", 0);
		check("irq on", irq, 1'b1);
		wr(`HPR_OFF_IM, 32'h0);
		check("irq masked", irq, 1'b0);
		wr(`HPR_OFF_IC, 32'h1);
		rdc(`HPR_OFF_RIS, 32'h0, "match cleared", 0);
	endtask
	// Sleep with match wake only, then with pin wake only.
	task automatic t_sleep;
		wr(`HPR_OFF_MATCH0, 32'h100);
		wr(`HPR_OFF_IC, 32'hf);
		wr(`HPR_OFF_CTL, 32'h4e);
		wait_reg(1'b0);
		wakeReq <= 1'b1;
		repeat (8) @(posedge core_clk);
		wakeReq <= 1'b0;
		check("pin ignored", regulator_off_n, 1'b0);
		check("supply off", powerGood, 1'b0);
		wr(`HPR_OFF_LOAD, 32'h100);
		wait_reg(1'b1);
		wr(`HPR_OFF_IC, 32'hf);
		wr(`HPR_OFF_CTL, 32'h56);
		wait_reg(1'b0);
		wakeReq <= 1'b1;
		wait_reg(1'b1);
		wakeReq <= 1'b0;
		rdc(`HPR_OFF_RIS, 32'h8, "wake raw", 1);
		rdc(`HPR_OFF_CTL, 32'h54, "req cleared", 0);
		check("supply on", powerGood, 1'b1);
	endtask
	// Sleep request refused while the battery is weak.
	task automatic t_abort;
		batLow <= 1'b1;
		repeat (4) @(posedge core_clk);
		wr(`HPR_OFF_IC, 32'hf);
		wr(`HPR_OFF_CTL, 32'hf6);
		check("abort keeps power", regulator_off_n, 1'b1);
		rdc(`HPR_OFF_RIS, 32'h4, "battery raw", 1);
		rdc(`HPR_OFF_CTL, 32'hf4, "req dropped", 0);
		batLow <= 1'b0;
	endtask
	// A write while the clock enable is low must leave state untouched.
	task automatic t_freeze;
		clkEn <= 1'b0;
		wr(`HPR_OFF_TRIM, 32'h1234);
		clkEn <= 1'b1;
		rdc(`HPR_OFF_TRIM, 32'h8001, "trim frozen", 0);
	endtask
	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Reset, then the scenarios in turn.
	initial begin
		{rst_b, psel, penable, pwrite, wakeReq, batLow} = 6'h0;
		clkEn = 1'b1;
		paddr = 12'h0;
		pwdata = 32'h0;
		fail_count = 0;
		n_compared = 0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_match;
		t_sleep;
		t_abort;
		t_freeze;
		test_done;
	end
endmodule
